// File: hdl/wtr_map.vh
/*
 Constant map of the watchdog time-out and reset-cause block:
 register offsets, field positions, reset values, vector words and counts.
 Assumes it is included by bare name from design files only.
*/
// Behaviour
// - Four-bit time-out select, top bit at control bit 5, rest at bits 2:0.
// - Codes 0..9 time out after 2048 oscillator cycles shifted left by code.
// - Reset-cause bits 7:4 always read zero.
// - Watchdog reset sets cause bit 3; power-on or written zero clears it.
// - Brown-out reset sets cause bit 2; power-on or written zero clears it.
// - Pin reset sets cause bit 1; power-on or written zero clears it.
// - Power-on sets cause bit 0; only a written zero clears it.
// - Any reset restarts at word 0x0000; watchdog interrupt goes to 0x0004.
// - Counter advances on a dedicated 128 kHz oscillator, not system clock.
// - Reset enable forced to one while watchdog flag set.
`ifndef WTR_MAP_VH
`define WTR_MAP_VH

// Register byte offsets
`define WTR_OFF_CTRL   8'h00
`define WTR_OFF_CAUSE  8'h04
`define WTR_OFF_KICK   8'h08
`define WTR_OFF_STAT   8'h0c
`define WTR_OFF_MASK   8'h10

// Control register fields
`define WTR_CTRL_IFLAG 7
`define WTR_CTRL_IE    6
`define WTR_CTRL_SEL3  5
`define WTR_CTRL_WE    3
`define WTR_CTRL_RST   8'h00

// Reset-cause fields
`define WTR_CAUSE_WD   3
`define WTR_CAUSE_BO   2
`define WTR_CAUSE_PIN  1
`define WTR_CAUSE_POR  0
`define WTR_CAUSE_RST  4'h1

// Interrupt status fields
`define WTR_IRQ_TO     0
`define WTR_IRQ_RST    1

// Vector words and counts
`define WTR_VEC_RESET  16'h0000
`define WTR_VEC_WDT    16'h0004
`define WTR_BASE_CYC   21'h000800
`define WTR_SEL_MAX    4'h9

`endif

// File: hdl/wtr_watchdog.v
/*
 Watchdog time-out counter with selectable period, reset-cause flags,
 vector selection and an AXI4-Lite register slave.
 Assumes a 100 MHz clk, a free-running watchdog oscillator far slower
 than clk, and asynchronous brown-out and pin reset event inputs.
*/
`timescale 1ns/1ps
`default_nettype none
`include "wtr_map.vh"

module wtr_watchdog #(
    parameter CNT_W = 21
)(
    // System
    input  wire        clk,
    input  wire        rst_n,
    // AXI4-Lite write address and data
    input  wire [7:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    // AXI4-Lite write response
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    // AXI4-Lite read
    input  wire [7:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    // Asynchronous sources
    input  wire        wdt_osc,
    input  wire        brownout_rst,
    input  wire        pin_rst,
    // Core side, same clock
    input  wire        kick,
    input  wire        vec_ack,
    // Results
    output reg         wdt_rst_req,
    output reg         vector_valid,
    output reg  [15:0] vector_addr,
    output reg         irq
);

    localparam [2:0] RG_CTRL  = 3'd0;
    localparam [2:0] RG_CAUSE = 3'd1;
    localparam [2:0] RG_KICK  = 3'd2;
    localparam [2:0] RG_STAT  = 3'd3;
    localparam [2:0] RG_MASK  = 3'd4;
    localparam [2:0] RG_NONE  = 3'd7;

    // Address decode, shared by read and write paths
    function [2:0] dec;
        input [7:0] a;
        begin
            case (a)
                `WTR_OFF_CTRL:  dec = RG_CTRL;
                `WTR_OFF_CAUSE: dec = RG_CAUSE;
                `WTR_OFF_KICK:  dec = RG_KICK;
                `WTR_OFF_STAT:  dec = RG_STAT;
                `WTR_OFF_MASK:  dec = RG_MASK;
                default:        dec = RG_NONE;
            endcase
        end
    endfunction

    // Last count before time-out for a select code
    function [CNT_W-1:0] lim;
        input [3:0] code;
        begin
            lim = (`WTR_BASE_CYC << code) - 21'h000001;
        end
    endfunction

    // Control and flag state
    reg  [3:0]       sel_r;
    reg              ie_r;
    reg              we_r;
    reg              iflag_r;
    reg  [3:0]       cause_r;
    reg  [1:0]       stat_r;
    reg  [1:0]       mask_r;
    reg  [CNT_W-1:0] cnt_r;
    // Synchronisers: osc, brown-out, pin
    reg  [2:0]       s1_r;
    reg  [2:0]       s2_r;
    reg  [2:0]       s3_r;
    // Bus holding state
    reg              aw_full_r;
    reg  [7:0]       aw_addr_r;
    reg              w_full_r;
    reg  [7:0]       w_data_r;
    reg              w_strb_r;

    wire [2:0] rise;
    wire       tick;
    wire       bo_evt;
    wire       pin_evt;
    wire       running;
    wire       sel_ok;
    wire       to_evt;
    wire       wd_evt;
    wire       rst_evt;
    wire       do_wr;
    wire [2:0] wr_sel;
    wire [2:0] rd_sel;
    wire       wr_ctrl;
    wire       wr_cause;
    wire       wr_kick;
    wire       wr_mask;
    wire       rd_stat;

    // Edges only from second and third stages; first stage stays private
    assign rise    = s2_r & ~s3_r;
    assign tick    = rise[0];
    assign bo_evt  = rise[1];
    assign pin_evt = rise[2];

    // Time-out decode; reserved codes never time out
    assign running = ie_r | we_r;
    assign sel_ok  = (sel_r <= `WTR_SEL_MAX);
    assign to_evt  = tick & running & sel_ok & (cnt_r == lim(sel_r));
    // With WE set, reset when no interrupt armed, or a second time-out beat the vector
    assign wd_evt  = to_evt & we_r & (~ie_r | iflag_r);
    assign rst_evt = wd_evt | bo_evt | pin_evt;

    // Write and read strobes
    assign do_wr    = aw_full_r & w_full_r & ~s_axi_bvalid;
    assign wr_sel   = dec(aw_addr_r);
    assign rd_sel   = dec(s_axi_araddr);
    assign wr_ctrl  = do_wr & w_strb_r & (wr_sel == RG_CTRL);
    assign wr_cause = do_wr & w_strb_r & (wr_sel == RG_CAUSE);
    assign wr_kick  = do_wr & w_strb_r & (wr_sel == RG_KICK) & w_data_r[0];
    assign wr_mask  = do_wr & w_strb_r & (wr_sel == RG_MASK);
    assign rd_stat  = s_axi_arvalid & s_axi_arready & (rd_sel == RG_STAT);

    // Two-flop synchronisers plus edge stage
    always @(posedge clk)
    begin
        if (!rst_n)
        begin
            s1_r <= 3'h0;
            s2_r <= 3'h0;
            s3_r <= 3'h0;
        end
        else
        begin
            s1_r <= {pin_rst, brownout_rst, wdt_osc};
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    // Watchdog counter on oscillator ticks
    always @(posedge clk)
    begin
        if (!rst_n)
            cnt_r <= {CNT_W{1'b0}};
        else if (rst_evt || kick || wr_kick || !running)
            cnt_r <= {CNT_W{1'b0}};
        else if (to_evt)
            cnt_r <= {CNT_W{1'b0}};
        else if (tick && sel_ok)
            cnt_r <= cnt_r + 21'h000001;
    end

    // Control register; watchdog, brown-out and pin resets clear select, IE and flag, and set WE
    always @(posedge clk)
    begin
        if (!rst_n)
        begin
            sel_r   <= 4'h0;
            ie_r    <= 1'b0;
            we_r    <= 1'b0;
            iflag_r <= 1'b0;
        end
        else if (rst_evt)
        begin
            sel_r   <= 4'h0;
            ie_r    <= 1'b0;
            we_r    <= 1'b1;
            iflag_r <= 1'b0;
        end
        else
        begin
            if (wr_ctrl)
            begin
                sel_r <= {w_data_r[`WTR_CTRL_SEL3], w_data_r[2:0]};
                ie_r  <= w_data_r[`WTR_CTRL_IE];
                we_r  <= w_data_r[`WTR_CTRL_WE] | cause_r[`WTR_CAUSE_WD];
            end
            else if (vec_ack && iflag_r && we_r)
                ie_r <= 1'b0; // Back to reset mode after the vector
            else if (cause_r[`WTR_CAUSE_WD])
                we_r <= 1'b1;
            // Flag: time-out sets, vector or written one clears; set wins
            if (to_evt && ie_r)
                iflag_r <= 1'b1;
            else if (vec_ack || (wr_ctrl && w_data_r[`WTR_CTRL_IFLAG]))
                iflag_r <= 1'b0;
        end
    end

    // Reset-cause flags survive every reset except power-on
    always @(posedge clk)
    begin
        if (!rst_n)
            cause_r <= `WTR_CAUSE_RST;
        else
        begin
            // A written zero clears; a same-cycle event still sets
            cause_r[`WTR_CAUSE_WD]  <= (cause_r[`WTR_CAUSE_WD]
                & ~(wr_cause & ~w_data_r[`WTR_CAUSE_WD])) | wd_evt;
            cause_r[`WTR_CAUSE_BO]  <= (cause_r[`WTR_CAUSE_BO]
                & ~(wr_cause & ~w_data_r[`WTR_CAUSE_BO])) | bo_evt;
            cause_r[`WTR_CAUSE_PIN] <= (cause_r[`WTR_CAUSE_PIN]
                & ~(wr_cause & ~w_data_r[`WTR_CAUSE_PIN])) | pin_evt;
            cause_r[`WTR_CAUSE_POR] <= cause_r[`WTR_CAUSE_POR]
                & ~(wr_cause & ~w_data_r[`WTR_CAUSE_POR]);
        end
    end

    // Sticky interrupt status, cleared by reading, set wins
    always @(posedge clk)
    begin
        if (!rst_n)
        begin
            stat_r <= 2'h0;
            mask_r <= 2'h0;
            irq    <= 1'b0;
        end
        else
        begin
            stat_r[`WTR_IRQ_TO]  <= (stat_r[`WTR_IRQ_TO] & ~rd_stat) | to_evt;
            stat_r[`WTR_IRQ_RST] <= (stat_r[`WTR_IRQ_RST] & ~rd_stat) | rst_evt;
            if (wr_mask)
                mask_r <= w_data_r[1:0];
            irq <= |(stat_r & mask_r);
        end
    end

    // Vector request and reset pulse
    always @(posedge clk)
    begin
        if (!rst_n)
        begin
            wdt_rst_req  <= 1'b0;
            vector_valid <= 1'b1;
            vector_addr  <= `WTR_VEC_RESET;
        end
        else
        begin
            wdt_rst_req <= wd_evt;
            if (rst_evt)
            begin
                vector_valid <= 1'b1;
                vector_addr  <= `WTR_VEC_RESET;
            end
            else if (iflag_r && ie_r && !vec_ack)
            begin
                vector_valid <= 1'b1;
                vector_addr  <= `WTR_VEC_WDT;
            end
            else
            begin
                vector_valid <= 1'b0;
                vector_addr  <= `WTR_VEC_RESET;
            end
        end
    end

    // Write channel: address and data taken in either order
    always @(posedge clk)
    begin
        if (!rst_n)
        begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= 2'b00;
            aw_full_r     <= 1'b0;
            aw_addr_r     <= 8'h00;
            w_full_r      <= 1'b0;
            w_data_r      <= 8'h00;
            w_strb_r      <= 1'b0;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_full_r     <= 1'b1;
                aw_addr_r     <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_full_r     <= 1'b1;
                w_data_r     <= s_axi_wdata[7:0];
                w_strb_r     <= s_axi_wstrb[0];
                s_axi_wready <= 1'b0;
            end
            if (do_wr)
            begin
                aw_full_r    <= 1'b0;
                w_full_r     <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (wr_sel == RG_NONE) ? 2'b10 : 2'b00;
            end
            else if (s_axi_bvalid && s_axi_bready)
            begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    // Read channel: one read at a time, answer one edge after address
    always @(posedge clk)
    begin
        if (!rst_n)
        begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= 2'b00;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rresp   <= (rd_sel == RG_NONE) ? 2'b10 : 2'b00;
            case (rd_sel)
                RG_CTRL:  s_axi_rdata <= {24'h000000, iflag_r, ie_r,
                                          sel_r[3], 1'b0, we_r, sel_r[2:0]};
                RG_CAUSE: s_axi_rdata <= {28'h0000000, cause_r};
                RG_STAT:  s_axi_rdata <= {30'h00000000, stat_r};
                RG_MASK:  s_axi_rdata <= {30'h00000000, mask_r};
                default:  s_axi_rdata <= 32'h00000000;
            endcase
        end
        else if (s_axi_rvalid && s_axi_rready)
        begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

endmodule

`default_nettype wire

// File: verif/wtr_watchdog_chk.sv
/* Checker for the watchdog time-out and reset-cause block.
 Sees only top ports; bound to wtr_watchdog below. */
`timescale 1ns/1ps
`default_nettype none
module wtr_chk (
    // Clock and reset
    input wire logic        clk, rst_n,
    // Register bus
    input wire logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready,
    input wire logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready,
    input wire logic        s_axi_rvalid, s_axi_rready,
    input wire logic [7:0]  s_axi_araddr,
    input wire logic [31:0] s_axi_rdata,
    // Results
    input wire logic        wdt_rst_req, vector_valid,
    input wire logic [15:0] vector_addr
);
    logic [7:0] ra_r;
    // Address of the read in flight, to judge its data
    always @(posedge clk)
        if (!rst_n)
            ra_r <= 8'h00;
        else if (s_axi_arvalid && s_axi_arready)
            ra_r <= s_axi_araddr;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence s_rd_take; s_axi_arvalid && s_axi_arready; endsequence
    sequence s_rd_ans; s_axi_rvalid && !s_axi_arready; endsequence
    sequence s_wr_take; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready; endsequence
    AST_RD_ANS: assert property (s_rd_take |=> s_rd_ans) else $error("read not answered");
    AST_RD_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    AST_WR_ANS: assert property (s_wr_take |-> ##2 s_axi_bvalid) else $error("write not answered");
    AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("bvalid dropped");
    AST_RST_PULSE: assert property (wdt_rst_req |=> !wdt_rst_req) else $error("reset request too long");
    AST_RST_VEC: assert property (wdt_rst_req |-> ##[0:1] (vector_valid && vector_addr == 16'h0000))
        else $error("reset vector missing");
    AST_VEC_LEGAL: assert property (vector_valid |-> vector_addr inside {16'h0000, 16'h0004})
        else $error("bad vector");
    AST_CAUSE_HI: assert property (s_axi_rvalid && ra_r == 8'h04 |-> s_axi_rdata[7:4] == 4'h0)
        else $error("cause upper bits set");
    AST_RD_UPPER: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000) else $error("upper data set");
endmodule
bind wtr_watchdog wtr_chk chk_u (.clk(clk), .rst_n(rst_n), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .s_axi_araddr(s_axi_araddr), .s_axi_rdata(s_axi_rdata), .wdt_rst_req(wdt_rst_req),
    .vector_valid(vector_valid), .vector_addr(vector_addr));
`default_nettype wire

// File: verif/wtr_watchdog_bench.sv
/* Self-checking bench for the watchdog block.
 Assumes the checker is bound to the design; oscillator is a clk/4 divider. */
`timescale 1ns/1ps
`default_nettype none
module wtr_watchdog_bench;
    logic        clk = 1'b0, rst_n = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic        arvalid = 1'b0, rready = 1'b0, osc = 1'b0, bo = 1'b0, pin = 1'b0, vack = 1'b0;
    logic        kick = 1'b0;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic        awready, wready, bvalid, arready, rvalid, rst_req, vvalid, irq;
    logic [1:0]  bresp, rresp;
    logic [31:0] rdata;
    logic [15:0] vaddr;
    logic [1:0]  div = 2'h0;
    int          n_fail = 0, n_tests = 0, cyc = 0;
    wtr_watchdog dut_u (.clk(clk), .rst_n(rst_n), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'h1), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .wdt_osc(osc),
        .brownout_rst(bo), .pin_rst(pin), .kick(kick), .vec_ack(vack), .wdt_rst_req(rst_req),
        .vector_valid(vvalid), .vector_addr(vaddr), .irq(irq));
    // Clock, oscillator at a quarter of clk to keep long counts short
    always #5 clk = ~clk;
    always @(posedge clk)
    begin
        div <= div + 2'h1;
        if (div[0])
            osc <= ~osc;
    end
    // Hang guard, well above the longest expected run
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 90000)
        begin
            n_fail++;
            finish_test();
        end
    end
    task finish_test;
    begin
        $display("comparisons %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    end
    endtask
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    begin
        n_tests++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    end
    endtask
    task tk(input int n);
        repeat (n) @(posedge clk);
    endtask
    // Write: address and data offered together, each dropped once taken
    task wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
    begin
        @(posedge clk);
        awaddr <= a;
        wdata <= {24'h000000, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do
        begin
            @(posedge clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        bready <= 1'b0;
        chk("bresp", {30'h0, bresp}, {30'h0, er});
    end
    endtask
    // Read; a nonzero gap holds rready low for gap plus one cycles of rvalid
    task rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er, input int gap = 0);
    begin
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= (gap == 0);
        do
        begin
            @(posedge clk);
            if (arready) arvalid <= 1'b0;
            if (rvalid && !rready)
            begin
                if (gap > 0) gap--;
                else rready <= 1'b1;
            end
        end while (!(rvalid && rready));
        rready <= 1'b0;
        chk("rdata", rdata, e);
        chk("rresp", {30'h0, rresp}, {30'h0, er});
    end
    endtask
    task por;
    begin
        @(posedge clk);
        rst_n <= 1'b0;
        tk(20);
        rst_n <= 1'b1;
        tk(1);
    end
    endtask
    // Asynchronous reset event held a few cycles so the synchroniser sees it
    task evt(input bit is_pin);
    begin
        @(posedge clk);
        if (is_pin) pin <= 1'b1;
        else bo <= 1'b1;
        tk(4);
        pin <= 1'b0;
        bo <= 1'b0;
        tk(8);
    end
    endtask
    task wait_rst(input int lo, input int hi);
        int n;
    begin
        n = 0;
        // Step past the edge first, so a pulse just reported is not seen twice
        do
        begin
            @(posedge clk);
            n++;
        end while (!rst_req && n < hi + 20);
        chk("reset_time", {31'h0, n >= lo && n <= hi}, 32'h1);
    end
    endtask
    task t_regs;
    begin
        rd(8'h00, 32'h0, 2'h0);
        rd(8'h14, 32'h0, 2'h2);
        wr(8'h14, 8'hff, 2'h2);
        wr(8'h00, 8'h31, 2'h0);
        rd(8'h00, 32'h21, 2'h0);
        wr(8'h00, 8'h00, 2'h0);
    end
    endtask
    task t_cause;
    begin
        rd(8'h04, 32'h1, 2'h0);
        evt(1'b1);
        rd(8'h04, 32'h3, 2'h0);
        evt(1'b0);
        rd(8'h04, 32'h7, 2'h0);
        wr(8'h04, 8'hfb, 2'h0);
        rd(8'h04, 32'h3, 2'h0);
        wr(8'h04, 8'h00, 2'h0);
        rd(8'h04, 32'h0, 2'h0);
        evt(1'b1);
        por();
        rd(8'h04, 32'h1, 2'h0);
    end
    endtask
    task t_wdog;
    begin
        wr(8'h04, 8'h00, 2'h0);
        wr(8'h00, 8'h09, 2'h0);
        wait_rst(16384 - 16, 16384 + 16);
        wait_rst(8192 - 4, 8192 + 4);
        rd(8'h04, 32'h8, 2'h0);
        wr(8'h00, 8'h00, 2'h0);
        rd(8'h00, 32'h08, 2'h0);
        wr(8'h04, 8'h00, 2'h0);
        wr(8'h00, 8'h00, 2'h0);
        rd(8'h00, 32'h00, 2'h0);
    end
    endtask
    // Kick port and kick register both restart the count
    task t_kick;
    begin
        wr(8'h04, 8'h00, 2'h0);
        wr(8'h00, 8'h08, 2'h0);
        tk(6000);
        kick <= 1'b1;
        tk(1);
        kick <= 1'b0;
        tk(4000);
        rd(8'h04, 32'h0, 2'h0);
        wr(8'h08, 8'h01, 2'h0);
        wait_rst(8192 - 8, 8192 + 8);
        rd(8'h04, 32'h8, 2'h0);
        wr(8'h04, 8'h00, 2'h0);
        wr(8'h00, 8'h00, 2'h0);
    end
    endtask
    task t_irq;
        int n;
    begin
        wr(8'h10, 8'h00, 2'h0);
        wr(8'h00, 8'h40, 2'h0);
        n = 0;
        while (!(vvalid === 1'b1 && vaddr === 16'h0004) && n < 9000)
        begin
            @(posedge clk);
            n++;
        end
        chk("vector", {16'h0, vaddr}, 32'h4);
        chk("irq_masked", {31'h0, irq}, 32'h0);
        wr(8'h10, 8'h01, 2'h0);
        tk(3);
        chk("irq", {31'h0, irq}, 32'h1);
        // Reset events of earlier scenarios left the reset-event bit set too
        rd(8'h0c, 32'h3, 2'h0);
        tk(3);
        chk("irq_clr", {31'h0, irq}, 32'h0);
        rd(8'h00, 32'hc0, 2'h0, 2);
        vack <= 1'b1;
        tk(1);
        vack <= 1'b0;
        tk(3);
        chk("vec_done", {31'h0, vvalid}, 32'h0);
        wr(8'h00, 8'h00, 2'h0);
    end
    endtask
    // Main sequence
    initial
    begin
        por();
        t_regs();
        t_cause();
        t_wdog();
        t_kick();
        t_irq();
        finish_test();
    end
endmodule
`default_nettype wire
